// *** rtl/mcr_pkg.sv ***
// Purpose: constants for the magnetometer configuration and readout block
// Assumes: one 100 MHz clock, memory words 16 bits wide, word pointer 8 bits
// Notes:   config word at 0x02 carries output function, interval and bus address
// Notes on behaviour
// (RULE1) config word 0x02, bits 8:7 choose the threshold output function
// (RULE2) config bits 14:12 choose the cyclic measurement interval
// (RULE3) config bits 6:0 hold the seven-bit bus slave address
// (RULE4) new slave address is used only after the next power-on reset; reset here also reloads config 0x02 to 0x0000, so the address stays 0x00
// (RULE5) master must never program slave addresses 4 to 8
// (RULE6) field result is 24-bit offset binary, 0x800000 means zero field
// (RULE7) threshold levels come from words 0x13, 0x14 and 0x15
// (RULE8) threshold output follows comparisons only when the function field enables it
// (RULE9) field and temperature offsets come from words 0x17, 0x18, 0x19
// (RULE10) signed offset shifts result up or down, range half of full scale
// (RULE11) normal mode refreshes data and output only on a master read
// (RULE12) cyclic mode refreshes data and output by itself at the interval
// (RULE13) each result averages a programmable number of samples
// (RULE14) temperature is reported as a 24-bit result beside the field
// (RULE15) thresholds: low 16 bits in own words, upper bytes share one word
// (RULE16) offsets split the same way, upper bytes share one word
// (RULE17) output sets above upper level, clears below lower level
package mcr_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INTERVAL_BASE_US = 1000;
  localparam int INTERVAL_BASE_CYC = INTERVAL_BASE_US * CLK_MHZ;

  // word addresses
  localparam logic [7:0] ADR_CONFIG     = 8'h02;
  localparam logic [7:0] ADR_MEAS_CTRL  = 8'h03;
  localparam logic [7:0] ADR_THR1_LO    = 8'h13;
  localparam logic [7:0] ADR_THR2_LO    = 8'h14;
  localparam logic [7:0] ADR_THR_HI     = 8'h15;
  localparam logic [7:0] ADR_OFS_FLD_LO = 8'h17;
  localparam logic [7:0] ADR_OFS_TMP_LO = 8'h18;
  localparam logic [7:0] ADR_OFS_HI     = 8'h19;
  localparam logic [7:0] ADR_FIELD_LO   = 8'h20;
  localparam logic [7:0] ADR_TEMP_LO    = 8'h21;
  localparam logic [7:0] ADR_RESULT_HI  = 8'h22;
  localparam int USER_WORDS = 32;

  // field positions
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_DOUT_LSB = 7;
  localparam int CFG_IVL_LSB  = 12;
  localparam int MC_OS_LSB    = 0;
  localparam int MC_CYCLIC    = 3;

  // values after reset
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [15:0] RST_THR_HI = 16'h40c0;
  localparam logic [15:0] RST_OFS_HI = 16'h00a1;
  localparam logic [23:0] ZERO_FIELD = 24'h800000;

  typedef enum logic [1:0] {
    DO_OFF      = 2'b00,
    DO_HYST     = 2'b01,
    DO_HYST_INV = 2'b10,
    DO_OFF_ALT  = 2'b11
  } mcr_dout_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WBYTE = 3'b011,
    ST_WACK  = 3'b100,
    ST_RBYTE = 3'b101,
    ST_RACK  = 3'b110
  } mcr_bus_e;
endpackage

// *** rtl/mcr_top.sv ***
// Purpose: bus slave, memory words, averaging, offset and threshold output
// Assumes: scl and sda inputs are synchronous to clk_sys; raw samples arrive
//          with a one-cycle raw_valid pulse from the front end
// Notes:   sda is open drain: sda_oe high pulls the line low
module mcr_top #(
  parameter int unsigned IVL_BASE_CYC = mcr_pkg::INTERVAL_BASE_CYC,
  parameter int          OS_W         = 3
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // two-wire bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // front end samples
  input  wire logic [23:0] raw_field,
  input  wire logic [23:0] raw_temp,
  input  wire logic        raw_valid,
  // status
  output logic             dout,
  output logic             meas_busy
);
  localparam int ACC_W = 24 + (1 << OS_W) - 1;

  function automatic logic [15:0] init_word(input int i);
    case (i)
      int'(mcr_pkg::ADR_CONFIG): init_word = mcr_pkg::RST_CONFIG;
      int'(mcr_pkg::ADR_THR_HI): init_word = mcr_pkg::RST_THR_HI;
      int'(mcr_pkg::ADR_OFS_HI): init_word = mcr_pkg::RST_OFS_HI;
      default:                   init_word = 16'h0000;
    endcase
  endfunction

  // adds a signed offset and clamps to the code range
  function automatic logic [23:0] add_ofs(input logic [23:0] code, input logic [23:0] ofs);
    logic signed [25:0] s;
    s = $signed({2'b00, code}) + $signed({{2{ofs[23]}}, ofs});
    if (s < 0)
      add_ofs = 24'h000000;
    else if (s > 26'sh0ffffff)
      add_ofs = 24'hffffff;
    else
      add_ofs = s[23:0];
  endfunction

  // memory words
  logic [15:0] mem_r [0:mcr_pkg::USER_WORDS-1];
  logic        wr_stb_r;
  logic [7:0]  wr_addr_r;
  logic [15:0] wr_data_r;

  // bus slave state
  mcr_pkg::mcr_bus_e state_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [7:0] wbuf_r;
  logic       have_ptr_r;
  logic       hi_r;
  logic       rw_r;
  logic       nack_r;
  logic       sda_oe_r;
  logic       sda_out_r;
  logic [6:0] own_addr_r;
  logic       addr_loaded_r;
  logic       req_bus_r;

  // measurement state
  logic [31:0]     ivl_cnt_r;
  logic            tick_r;
  logic            busy_r;
  logic [7:0]      smp_cnt_r;
  logic [OS_W-1:0] os_r;
  logic [ACC_W-1:0] acc_f_r;
  logic [ACC_W-1:0] acc_t_r;
  logic [23:0]     field_r;
  logic [23:0]     temp_r;
  logic            dout_r;

  // decoded memory fields
  wire logic [15:0] cfg_w      = mem_r[mcr_pkg::ADR_CONFIG[4:0]];
  wire logic [15:0] mctl_w     = mem_r[mcr_pkg::ADR_MEAS_CTRL[4:0]];
  wire logic [1:0]  dout_fn_w  = cfg_w[mcr_pkg::CFG_DOUT_LSB +: 2];              // [RULE1]
  wire logic [2:0]  ivl_sel_w  = cfg_w[mcr_pkg::CFG_IVL_LSB +: 3];               // [RULE2]
  wire logic        cyclic_w   = mctl_w[mcr_pkg::MC_CYCLIC];
  wire logic [OS_W-1:0] os_w   = mctl_w[mcr_pkg::MC_OS_LSB +: OS_W];
  wire logic [15:0] thr_hi_w   = mem_r[mcr_pkg::ADR_THR_HI[4:0]];
  wire logic [15:0] ofs_hi_w   = mem_r[mcr_pkg::ADR_OFS_HI[4:0]];
  wire logic [23:0] upper_switch_level =
    {thr_hi_w[7:0], mem_r[mcr_pkg::ADR_THR1_LO[4:0]]};                           // [RULE7] [RULE15]
  wire logic [23:0] lower_switch_level =
    {thr_hi_w[15:8], mem_r[mcr_pkg::ADR_THR2_LO[4:0]]};                          // [RULE7] [RULE15]
  wire logic [23:0] ofs_fld_w  =
    {ofs_hi_w[7:0], mem_r[mcr_pkg::ADR_OFS_FLD_LO[4:0]]};                        // [RULE9] [RULE16]
  wire logic [23:0] ofs_tmp_w  =
    {ofs_hi_w[15:8], mem_r[mcr_pkg::ADR_OFS_TMP_LO[4:0]]};                       // [RULE9] [RULE16]

  // bus edge and condition decode
  wire logic scl_rise = scl_in & ~scl_q_r;
  wire logic scl_fall = ~scl_in & scl_q_r;
  wire logic start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire logic stop_det  = scl_in & scl_q_r & ~sda_q_r & sda_in;
  wire logic byte_in   = (bit_cnt_r == 4'h8);
  wire logic addr_hit  = (shift_r[7:1] == own_addr_r);                           // [RULE3] [RULE4]

  // read data select
  wire logic in_user = (ptr_r < 8'(mcr_pkg::USER_WORDS));
  wire logic [15:0] rd_word =
    in_user                               ? mem_r[ptr_r[4:0]] :
    (ptr_r == mcr_pkg::ADR_FIELD_LO)      ? field_r[15:0] :
    (ptr_r == mcr_pkg::ADR_TEMP_LO)       ? temp_r[15:0] :
    (ptr_r == mcr_pkg::ADR_RESULT_HI)     ? {temp_r[23:16], field_r[23:16]} :    // [RULE14]
                                            16'h0000;
  wire logic [7:0] rd_byte = hi_r ? rd_word[15:8] : rd_word[7:0];

  // averaging and correction
  wire logic [ACC_W-1:0] sum_f   = acc_f_r + ACC_W'(raw_field);
  wire logic [ACC_W-1:0] sum_t   = acc_t_r + ACC_W'(raw_temp);
  wire logic [7:0]       last_smp = 8'((9'h001 << os_r) - 9'h001);               // [RULE13]
  wire logic             smp_last = busy_r & raw_valid & (smp_cnt_r == last_smp);
  wire logic [23:0] avg_f  = 24'(sum_f >> os_r);                                 // [RULE13]
  wire logic [23:0] avg_t  = 24'(sum_t >> os_r);
  wire logic [23:0] corr_f = add_ofs(avg_f, ofs_fld_w);                          // [RULE6] [RULE10]
  wire logic [23:0] corr_t = add_ofs(avg_t, ofs_tmp_w);                          // [RULE10] [RULE14]
  wire logic [31:0] period = 32'(IVL_BASE_CYC) << ivl_sel_w;                    // [RULE2]
  wire logic meas_req = cyclic_w ? tick_r : req_bus_r;                           // [RULE11] [RULE12]

  // threshold output next value
  wire logic above   = (corr_f > upper_switch_level);
  wire logic below   = (corr_f < lower_switch_level);
  wire logic hyst_en = (dout_fn_w == mcr_pkg::DO_HYST) || (dout_fn_w == mcr_pkg::DO_HYST_INV);
  wire logic hyst_nxt = above ? 1'b1 :
                        (below ? 1'b0 : (dout_r ^ (dout_fn_w == mcr_pkg::DO_HYST_INV)));
  wire logic dout_nxt = !hyst_en ? 1'b0 :                                        // [RULE8]
                        (hyst_nxt ^ (dout_fn_w == mcr_pkg::DO_HYST_INV));        // [RULE17]

  // memory words, written from the bus
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < mcr_pkg::USER_WORDS; i++) begin
        mem_r[i] <= init_word(i);
      end
    end else if (wr_stb_r && (wr_addr_r < 8'(mcr_pkg::USER_WORDS))) begin
      mem_r[wr_addr_r[4:0]] <= wr_data_r;
    end
  end

  // slave address is caught once after reset and never follows later writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      own_addr_r    <= 7'h00;
      addr_loaded_r <= 1'b0;
    end else if (!addr_loaded_r) begin
      own_addr_r    <= cfg_w[mcr_pkg::CFG_ADDR_LSB +: 7];                        // [RULE4]
      addr_loaded_r <= 1'b1;
    end
  end

  // bus slave
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= mcr_pkg::ST_IDLE;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      wbuf_r     <= 8'h00;
      have_ptr_r <= 1'b0;
      hi_r       <= 1'b1;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      sda_oe_r   <= 1'b0;
      sda_out_r  <= 1'b0;
      wr_stb_r   <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_data_r  <= 16'h0000;
      req_bus_r  <= 1'b0;
    end else begin
      scl_q_r   <= scl_in;
      sda_q_r   <= sda_in;
      sda_out_r <= 1'b0;
      wr_stb_r  <= 1'b0;
      req_bus_r <= 1'b0;
      if (start_det) begin
        state_r    <= mcr_pkg::ST_ADDR;
        bit_cnt_r  <= 4'h0;
        have_ptr_r <= 1'b0;
        hi_r       <= 1'b1;
        sda_oe_r   <= 1'b0;
      end else if (stop_det) begin
        state_r  <= mcr_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          mcr_pkg::ST_ADDR, mcr_pkg::ST_WBYTE: begin
            if (scl_rise && !byte_in) begin
              shift_r   <= {shift_r[6:0], sda_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && byte_in) begin
              bit_cnt_r <= 4'h0;
              if (state_r == mcr_pkg::ST_ADDR) begin
                if (addr_hit) begin
                  sda_oe_r  <= 1'b1;
                  rw_r      <= shift_r[0];
                  state_r   <= mcr_pkg::ST_AACK;
                  req_bus_r <= shift_r[0];                                       // [RULE11]
                end else begin
                  state_r <= mcr_pkg::ST_IDLE;
                end
              end else begin
                sda_oe_r <= 1'b1;
                state_r  <= mcr_pkg::ST_WACK;
                if (!have_ptr_r) begin
                  ptr_r      <= shift_r;
                  have_ptr_r <= 1'b1;
                  hi_r       <= 1'b1;
                end else if (hi_r) begin
                  wbuf_r <= shift_r;
                  hi_r   <= 1'b0;
                end else begin
                  wr_stb_r  <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= {wbuf_r, shift_r};
                  ptr_r     <= ptr_r + 8'h01;
                  hi_r      <= 1'b1;
                end
              end
            end
          end
          mcr_pkg::ST_AACK, mcr_pkg::ST_RACK: begin
            if (scl_rise) begin
              nack_r <= sda_in;
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (state_r == mcr_pkg::ST_RACK && nack_r) begin
                sda_oe_r <= 1'b0;
                state_r  <= mcr_pkg::ST_IDLE;
              end else if (rw_r) begin
                tx_r     <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                state_r  <= mcr_pkg::ST_RBYTE;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= mcr_pkg::ST_WBYTE;
              end
            end
          end
          mcr_pkg::ST_WACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r  <= mcr_pkg::ST_WBYTE;
            end
          end
          mcr_pkg::ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                sda_oe_r <= 1'b0;
                state_r  <= mcr_pkg::ST_RACK;
                hi_r     <= ~hi_r;
                if (!hi_r) begin
                  ptr_r <= ptr_r + 8'h01;
                end
              end else begin
                tx_r      <= {tx_r[6:0], 1'b0};
                sda_oe_r  <= ~tx_r[6];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // interval timer for cyclic mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ivl_cnt_r <= 32'h00000000;
      tick_r    <= 1'b0;
    end else if (!cyclic_w) begin
      ivl_cnt_r <= 32'h00000000;
      tick_r    <= 1'b0;
    end else if (ivl_cnt_r >= period - 32'h00000001) begin
      ivl_cnt_r <= 32'h00000000;
      tick_r    <= 1'b1;                                                         // [RULE12]
    end else begin
      ivl_cnt_r <= ivl_cnt_r + 32'h00000001;
      tick_r    <= 1'b0;
    end
  end

  // sample averaging, correction and threshold output
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_r    <= 1'b0;
      smp_cnt_r <= 8'h00;
      os_r      <= '0;
      acc_f_r   <= '0;
      acc_t_r   <= '0;
      field_r   <= mcr_pkg::ZERO_FIELD;
      temp_r    <= 24'h000000;
      dout_r    <= 1'b0;
    end else if (!busy_r) begin
      if (meas_req) begin
        busy_r    <= 1'b1;
        smp_cnt_r <= 8'h00;
        os_r      <= os_w;
        acc_f_r   <= '0;
        acc_t_r   <= '0;
      end
    end else if (smp_last) begin
      busy_r  <= 1'b0;
      field_r <= corr_f;                                                         // [RULE6]
      temp_r  <= corr_t;                                                         // [RULE14]
      dout_r  <= dout_nxt;                                                       // [RULE8] [RULE17]
    end else if (raw_valid) begin
      acc_f_r   <= sum_f;
      acc_t_r   <= sum_t;
      smp_cnt_r <= smp_cnt_r + 8'h01;
    end
  end

  assign sda_out   = sda_out_r;
  assign sda_oe    = sda_oe_r;
  assign dout      = dout_r;
  assign meas_busy = busy_r;
endmodule

// *** tb/mcr_top_asserts.sv ***
// Purpose: concurrent checks on the ports of the magnetometer block
// Assumes: the bus master holds scl low and high for at least four clocks
// Notes:   bound to mcr_top after the module
module mcr_top_asserts (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // two-wire bus
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // front end samples
  input wire logic [23:0] raw_field,
  input wire logic [23:0] raw_temp,
  input wire logic        raw_valid,
  // status
  input wire logic        dout,
  input wire logic        meas_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence start_seen;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence
  sequence stop_seen;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  quiet_after_reset_a: assert property (
    $rose(reset_n) |-> !sda_oe && !dout && !meas_busy)
    else $error("outputs active right after reset");
  sda_out_low_a: assert property (!sda_out)
    else $error("sda data output not held low");
  dout_needs_sample_a: assert property (!$stable(dout) |-> $past(raw_valid))
    else $error("dout moved without a sample");
  dout_at_end_a: assert property (!$stable(dout) |-> $past(meas_busy) && !meas_busy)
    else $error("dout moved outside the end of a measurement");
  busy_holds_a: assert property (meas_busy && !raw_valid |=> meas_busy)
    else $error("busy dropped without a sample");
  busy_ends_a: assert property ($fell(meas_busy) |-> $past(raw_valid))
    else $error("busy fell with no sample before it");
  oe_after_fall_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("sda drive changed outside scl low");
  oe_through_high_a: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*4])
    else $error("sda drive released during scl high");
  quiet_after_stop_a: assert property (stop_seen |=> !sda_oe [*3])
    else $error("sda driven after stop");
  no_early_ack_a: assert property (start_seen |=> !sda_oe [*8])
    else $error("sda driven during address bits");
endmodule

bind mcr_top mcr_top_asserts chk_u (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .raw_field(raw_field),
  .raw_temp(raw_temp), .raw_valid(raw_valid), .dout(dout), .meas_busy(meas_busy));

// *** tb/mcr_i2c_master.sv ***
// Purpose: two-wire bus master model doing word writes and reads
// Assumes: a released line reads high through the pull-up
// Notes:   q is clocks per third of a bit; raise it for a slow master
module mcr_i2c_master (
  // clock
  input  wire logic clk_sys,
  // bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int q = 4;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // eight data bits then the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda = tx[i];
      tick(q);
      scl = 1'b1;
      tick(q);
      rx[i] = sda_line;
      scl = 1'b0;
      tick(q);
    end
  endtask
  task automatic start();
    sda = 1'b1;
    tick(q);
    scl = 1'b1;
    tick(q);
    sda = 1'b0;
    tick(q);
    scl = 1'b0;
    tick(q);
  endtask
  task automatic stop();
    sda = 1'b0;
    tick(q);
    scl = 1'b1;
    tick(q);
    sda = 1'b1;
    tick(q);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] d,
                    output logic ack);
    logic [8:0] r0, r1, r2, r3;
    start();
    xfer({dev, 2'b01}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d[15:8], 1'b1}, r2);
    xfer({d[7:0], 1'b1}, r3);
    stop();
    ack = !(r0[0] | r1[0] | r2[0] | r3[0]);
  endtask
  // pointer write, repeated start, one word read ended by a nack
  task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [15:0] d,
                    output logic ack);
    logic [8:0] r0, r1, r2, r3, r4;
    start();
    xfer({dev, 2'b01}, r0);
    xfer({p, 1'b1}, r1);
    start();
    xfer({dev, 2'b11}, r2);
    xfer(9'h1fe, r3);
    xfer(9'h1ff, r4);
    stop();
    d = {r3[8:1], r4[8:1]};
    ack = !(r0[0] | r1[0] | r2[0]);
  endtask
endmodule

// *** tb/mcr_top_tb.sv ***
// Purpose: self-checking bench for the magnetometer configuration block
// Assumes: master model on the bus, bench drives the front end samples
// Notes:   interval base shortened to 50 clocks
module mcr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        raw_valid = 1'b0;
  logic [23:0] raw_field = 24'h000000;
  logic [23:0] raw_temp  = 24'h000000;
  logic        scl, sda_m, sda_oe, dout, meas_busy, ak;
  logic [15:0] rv;
  logic [6:0]  dev = 7'h00;
  wire         sda_line = sda_m & ~sda_oe;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  logic [15:0] cfg_tab [8] = '{16'h0000, 16'h0080, 16'h0080, 16'h0080,
                               16'h0080, 16'h0100, 16'h0100, 16'h0180};
  logic [23:0] fld_tab [8] = '{24'ha00000, 24'ha00000, 24'h800000, 24'h600000,
                               24'h800000, 24'h600000, 24'ha00000, 24'h600000};
  logic        exp_tab [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  always #5 clk_sys = ~clk_sys;

  mcr_top #(.IVL_BASE_CYC(50), .OS_W(3)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(), .sda_oe(sda_oe), .raw_field(raw_field), .raw_temp(raw_temp),
    .raw_valid(raw_valid), .dout(dout), .meas_busy(meas_busy));
  mcr_i2c_master mst_u (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda_m));

  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wreg(input logic [7:0] p, input logic [15:0] d);
    mst_u.wr(dev, p, d, ak);
    check("write ack", 24'(ak), 24'h000001);
  endtask
  task automatic rreg(input logic [7:0] p, input logic [15:0] e);
    mst_u.rd(dev, p, rv, ak);
    check("read ack", 24'(ak), 24'h000001);
    check($sformatf("word %h", p), 24'(rv), 24'(e));
  endtask
  task automatic samp(input logic [23:0] f, input logic [23:0] t);
    raw_field = f;
    raw_temp  = t;
    raw_valid = 1'b1;
    tick(1);
    raw_valid = 1'b0;
    tick(1);
  endtask
  task automatic flush(input logic [23:0] f);
    for (int i = 0; i < 300 && meas_busy; i++) samp(f, 24'h000000);
    if (meas_busy) begin
      check("flush wait", 24'h000001, 24'h000000);
      final_report();
    end
  endtask
  task automatic wait_busy(output int c);
    for (c = 0; c < 250 && !meas_busy; c++) tick(1);
    if (c == 250) begin
      check("busy wait", 24'h000000, 24'h000001);
      final_report();
    end
  endtask
  task automatic meas(input logic [15:0] cfg, input logic [23:0] f, input logic e);
    wreg(8'h02, cfg);
    flush(f);
    mst_u.rd(dev, 8'h20, rv, ak);
    check("busy on read", 24'(meas_busy), 24'h000001);
    samp(f, 24'h000000);
    check("dout", 24'(dout), 24'(e));
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    tick(2);
    rreg(8'h02, 16'h0000);
    rreg(8'h15, 16'h40c0);
    rreg(8'h19, 16'h00a1);
    rreg(8'h22, 16'h0080);
    rreg(8'h21, 16'h0000);
    wreg(8'h13, 16'h1234);
    wreg(8'h18, 16'hdef0);
    wreg(8'h20, 16'h5555);
    rreg(8'h13, 16'h1234);
    rreg(8'h18, 16'hdef0);
    rreg(8'h20, 16'h0000);
    rreg(8'h30, 16'h0000);
    // slow master; new address chosen outside the reserved 4..8 span
    mst_u.q = 8;
    wreg(8'h02, 16'h002a);
    rreg(8'h02, 16'h002a);
    dev = 7'h2a;
    mst_u.rd(dev, 8'h02, rv, ak);
    check("new address ack", 24'(ak), 24'h000000);
    dev = 7'h00;
    mst_u.q = 4;
    wreg(8'h03, 16'h0000);
    wreg(8'h13, 16'h0000);
    wreg(8'h14, 16'h0000);
    wreg(8'h15, 16'h7090);
    wreg(8'h19, 16'h0000);
    for (int i = 0; i < 8; i++) meas(cfg_tab[i], fld_tab[i], exp_tab[i]);
    wreg(8'h03, 16'h0001);
    wreg(8'h17, 16'h0100);
    wreg(8'h18, 16'hffff);
    wreg(8'h19, 16'hff00);
    mst_u.rd(dev, 8'h20, rv, ak);
    samp(24'h800000, 24'h000010);
    check("busy after one", 24'(meas_busy), 24'h000001);
    samp(24'h800002, 24'h000012);
    check("busy after two", 24'(meas_busy), 24'h000000);
    rreg(8'h20, 16'h0101);
    rreg(8'h21, 16'h0010);
    rreg(8'h22, 16'h0080);
    wreg(8'h03, 16'h0000);
    flush(24'h800000);
    tick(300);
    check("normal idle", 24'(meas_busy), 24'h000000);
    wreg(8'h02, 16'h1000);
    wreg(8'h03, 16'h0008);
    flush(24'h800000);
    wait_busy(n);
    samp(24'h800000, 24'h000000);
    wait_busy(n);
    check("cyclic interval", 24'(n >= 90 && n <= 100), 24'h000001);
    final_report();
  end
endmodule
